//--- hw/adrc_top.sv
// Purpose: Converter result path with redundant filter check and AXI4-Lite
// Assumes: Modulator bits arrive synchronous to i_ref_clk with a strobe
// Notes:   Checked and unchecked commands share one identical timeline

// -------------------------------------------------------------------
// Integration machine
// -------------------------------------------------------------------
module adrc_intg #(
  parameter int W = 16
) (
  input  wire logic         i_ref_clk,
  input  wire logic         i_rst_n,
  input  wire logic         i_clr,
  input  wire logic         i_stb,
  input  wire logic         i_bit,
  output logic      [W-1:0] o_acc
);

  // Integrate ones of the bitstream, cleared per conversion
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_acc <= '0;
    end else if (i_clr) begin
      o_acc <= '0;
    end else if (i_stb) begin
      o_acc <= o_acc + W'(i_bit);
    end
  end

endmodule

// -------------------------------------------------------------------
// Top
// -------------------------------------------------------------------
module adrc_top #(
  parameter int CONV_LEN = adrc_pkg::CONV_SAMPLES
) (
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst_n,
  input  wire logic [7:0]  i_awaddr,
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  output logic      [1:0]  o_bresp,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  input  wire logic [7:0]  i_araddr,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  output logic      [31:0] o_rdata,
  output logic      [1:0]  o_rresp,
  output logic             o_rvalid,
  input  wire logic        i_rready,
  input  wire logic        i_mod_stb,
  input  wire logic [2:0]  i_mod_bits
);

  localparam int CW = $clog2(CONV_LEN + 1);
  localparam logic [CW-1:0] LAST_SAMP = CW'(CONV_LEN - 1);

  adrc_pkg::adrc_cfg_s   cfg_r;
  adrc_pkg::adrc_cmd_e   cmd_r;
  adrc_pkg::adrc_state_e st_r;
  adrc_pkg::adrc_state_e st_nxt;
  logic [CW-1:0] samp_r;
  logic [1:0]    slot_r;
  logic [15:0]   sum_r;
  logic [15:0]   tmp_r;
  logic [15:0]   asup_r;
  logic [15:0]   dsup_r;
  logic [15:0]   res_r;
  logic          fault_r;
  logic [7:0]    awaddr_r;
  logic [31:0]   wdata_r;
  logic [3:0]    wstrb_r;
  logic          aw_held_r;
  logic          w_held_r;
  logic [15:0]   prim_acc;
  logic [15:0]   red_acc;

  // -----------------------------------------------------------------
  // Write decode
  // -----------------------------------------------------------------
  wire wr_go    = aw_held_r && w_held_r && !o_bvalid;
  wire wr_cfg   = awaddr_r == adrc_pkg::A_CFG;
  wire wr_cmd   = awaddr_r == adrc_pkg::A_CMD;
  wire wr_ro    = awaddr_r inside {adrc_pkg::A_SUM, adrc_pkg::A_TMP,
                                   adrc_pkg::A_ASUP, adrc_pkg::A_DSUP,
                                   adrc_pkg::A_RES};
  wire wr_ok    = wr_cfg || wr_cmd || wr_ro;
  wire cmd_legal = wdata_r[3:0] <= 4'(adrc_pkg::CELL_AND_SUM_CONVERT);
  wire busy     = st_r != adrc_pkg::ST_IDLE;
  wire start    = wr_go && wr_cmd && wstrb_r[0] && cmd_legal && !busy;

  // -----------------------------------------------------------------
  // Command class and path selection
  // -----------------------------------------------------------------
  wire int_cmd  = cmd_r inside {adrc_pkg::INTERNAL_PARAM_CONVERT,
                                adrc_pkg::INTERNAL_PARAM_CONVERT_CHECKED,
                                adrc_pkg::INTERNAL_PARAM_SELF_TEST};
  wire chk_cmd  = !(cmd_r inside {adrc_pkg::AUX_CONVERT,
                                  adrc_pkg::INTERNAL_PARAM_CONVERT});
  wire path_auto = cfg_r.path_select_field < adrc_pkg::PATH_FIX_MIN;
  // Automatic or low codes pick the first path, 2 and 3 fix the path
  wire [1:0] sel_adc = path_auto ? 2'h0
                     : cfg_r.path_select_field - 2'h1;
  wire adc_bit  = i_mod_bits[sel_adc];
  // Internal values have no redundant path when the path is fixed
  wire chk_on   = chk_cmd && (!int_cmd || path_auto);
  wire [1:0] last_slot = int_cmd ? adrc_pkg::SLOT_DSUP
                                 : adrc_pkg::SLOT_SUM;
  wire samp_end = st_r == adrc_pkg::ST_CONV && i_mod_stb
               && samp_r == LAST_SAMP;

  // -----------------------------------------------------------------
  // Primary and redundant machines on one bitstream
  // -----------------------------------------------------------------
  wire mach_clr = st_r != adrc_pkg::ST_CONV;
  wire mach_stb = st_r == adrc_pkg::ST_CONV && i_mod_stb;

  adrc_intg #(.W(16)) u_prim (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (i_rst_n),
    .i_clr     (mach_clr),
    .i_stb     (mach_stb),
    .i_bit     (adc_bit),
    .o_acc     (prim_acc)
  );

  adrc_intg #(.W(16)) u_red (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (i_rst_n),
    .i_clr     (mach_clr),
    .i_stb     (mach_stb),
    .i_bit     (adc_bit),
    .o_acc     (red_acc)
  );

  // -----------------------------------------------------------------
  // Nibble compare and fault code
  // -----------------------------------------------------------------
  wire [3:0] nib_bad = {prim_acc[15:12] != red_acc[15:12],
                        prim_acc[11:8]  != red_acc[11:8],
                        prim_acc[7:4]   != red_acc[7:4],
                        prim_acc[3:0]   != red_acc[3:0]};
  wire [3:0] flags   = cfg_r.force_redundancy_fail
                     ? adrc_pkg::ALL_NIB_BAD : nib_bad;
  wire       bad     = chk_on && (flags != 4'h0);
  wire [15:0] store_val = bad ? {adrc_pkg::FAULT_HI, flags}
                              : prim_acc;
  wire do_store = st_r == adrc_pkg::ST_STORE;

  // -----------------------------------------------------------------
  // Read decode
  // -----------------------------------------------------------------
  wire rd_hit = i_araddr inside {adrc_pkg::A_CFG, adrc_pkg::A_CMD,
                                 adrc_pkg::A_SUM, adrc_pkg::A_TMP,
                                 adrc_pkg::A_ASUP, adrc_pkg::A_DSUP,
                                 adrc_pkg::A_RES};
  wire [31:0] rd_word =
      i_araddr == adrc_pkg::A_CFG  ? {29'h0, cfg_r}
    : i_araddr == adrc_pkg::A_CMD  ? {30'h0, fault_r, busy}
    : i_araddr == adrc_pkg::A_SUM  ? {16'h0, sum_r}
    : i_araddr == adrc_pkg::A_TMP  ? {16'h0, tmp_r}
    : i_araddr == adrc_pkg::A_ASUP ? {16'h0, asup_r}
    : i_araddr == adrc_pkg::A_DSUP ? {16'h0, dsup_r}
    : i_araddr == adrc_pkg::A_RES ? {16'h0, res_r}
    : 32'h0;

  // -----------------------------------------------------------------
  // AXI4-Lite write channels
  // -----------------------------------------------------------------
  // Write address capture
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_awready <= 1'b1;
      aw_held_r <= 1'b0;
      awaddr_r  <= 8'h00;
    end else if (i_awvalid && o_awready) begin
      o_awready <= 1'b0;
      aw_held_r <= 1'b1;
      awaddr_r  <= i_awaddr;
    end else if (wr_go) begin
      aw_held_r <= 1'b0;
    end else if (o_bvalid && i_bready) begin
      o_awready <= 1'b1;
    end
  end

  // Write data capture
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_wready <= 1'b1;
      w_held_r <= 1'b0;
      wdata_r  <= 32'h0;
      wstrb_r  <= 4'h0;
    end else if (i_wvalid && o_wready) begin
      o_wready <= 1'b0;
      w_held_r <= 1'b1;
      wdata_r  <= i_wdata;
      wstrb_r  <= i_wstrb;
    end else if (wr_go) begin
      w_held_r <= 1'b0;
    end else if (o_bvalid && i_bready) begin
      o_wready <= 1'b1;
    end
  end

  // Write response
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_bvalid <= 1'b0;
      o_bresp  <= adrc_pkg::RESP_OKAY;
    end else if (wr_go) begin
      o_bvalid <= 1'b1;
      o_bresp  <= wr_ok ? adrc_pkg::RESP_OKAY : adrc_pkg::RESP_SLVERR;
    end else if (o_bvalid && i_bready) begin
      o_bvalid <= 1'b0;
    end
  end

  // Configuration register
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cfg_r <= {adrc_pkg::FORCE_RST, adrc_pkg::PATH_RST};
    end else if (wr_go && wr_cfg && wstrb_r[0]) begin
      cfg_r <= wdata_r[2:0];
    end
  end

  // -----------------------------------------------------------------
  // AXI4-Lite read channels
  // -----------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_arready <= 1'b1;
      o_rvalid  <= 1'b0;
      o_rdata   <= 32'h0;
      o_rresp   <= adrc_pkg::RESP_OKAY;
    end else if (i_arvalid && o_arready) begin
      o_arready <= 1'b0;
      o_rvalid  <= 1'b1;
      o_rdata   <= rd_word;
      o_rresp   <= rd_hit ? adrc_pkg::RESP_OKAY : adrc_pkg::RESP_SLVERR;
    end else if (o_rvalid && i_rready) begin
      o_arready <= 1'b1;
      o_rvalid  <= 1'b0;
    end
  end

  // -----------------------------------------------------------------
  // Conversion sequencer
  // -----------------------------------------------------------------
  // Same path for checked and unchecked commands, internal ones loop over four slots, store is always one cycle
  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      adrc_pkg::ST_IDLE:  if (start) st_nxt = adrc_pkg::ST_CONV;
      adrc_pkg::ST_CONV:  if (samp_end) st_nxt = adrc_pkg::ST_STORE;
      adrc_pkg::ST_STORE: st_nxt = (slot_r == last_slot)
                                 ? adrc_pkg::ST_IDLE : adrc_pkg::ST_CONV;
      default:            st_nxt = adrc_pkg::ST_IDLE;
    endcase
  end

  // State, sample and slot counters
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r   <= adrc_pkg::ST_IDLE;
      samp_r <= '0;
      slot_r <= adrc_pkg::SLOT_SUM;
      cmd_r  <= adrc_pkg::CELL_CONVERT;
    end else begin
      st_r <= st_nxt;
      if (start) begin
        cmd_r  <= adrc_pkg::adrc_cmd_e'(wdata_r[3:0]);
        slot_r <= adrc_pkg::SLOT_SUM;
      end else if (do_store) begin
        slot_r <= slot_r + 2'h1;
      end
      if (st_r != adrc_pkg::ST_CONV) begin
        samp_r <= '0;
      end else if (i_mod_stb) begin
        samp_r <= samp_r + CW'(1);
      end
    end
  end

  // Result storage
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sum_r   <= adrc_pkg::RES_RST;
      tmp_r   <= adrc_pkg::RES_RST;
      asup_r  <= adrc_pkg::RES_RST;
      dsup_r  <= adrc_pkg::RES_RST;
      res_r   <= adrc_pkg::RES_RST;
      fault_r <= 1'b0;
    end else if (start) begin
      fault_r <= 1'b0;
    end else if (do_store) begin
      fault_r <= fault_r || bad;
      if (!int_cmd) begin
        res_r <= store_val;
      end else begin
        unique case (slot_r)
          adrc_pkg::SLOT_SUM:  sum_r  <= store_val;
          adrc_pkg::SLOT_TMP:  tmp_r  <= store_val;
          adrc_pkg::SLOT_ASUP: asup_r <= store_val;
          adrc_pkg::SLOT_DSUP: dsup_r <= store_val;
        endcase
      end
    end
  end

  // -----------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);

  sequence seq_conv_end;
    st_r == adrc_pkg::ST_CONV && i_mod_stb && samp_r == LAST_SAMP;
  endsequence

  sequence seq_one_store;
    st_r == adrc_pkg::ST_STORE ##1 st_r != adrc_pkg::ST_STORE;
  endsequence

  sum_store_a: assert property (
    do_store && int_cmd && slot_r == adrc_pkg::SLOT_SUM
    |=> sum_r == $past(store_val))
    else $error("sum code not stored");

  temp_store_a: assert property (
    do_store && int_cmd && slot_r == adrc_pkg::SLOT_TMP
    |=> tmp_r == $past(store_val) && $stable(sum_r))
    else $error("temperature code not stored");

  supply_store_a: assert property (
    do_store && int_cmd && slot_r == adrc_pkg::SLOT_DSUP
    |=> dsup_r == $past(store_val) && $stable(asup_r)
    && st_r == adrc_pkg::ST_IDLE)
    else $error("supply code not stored");

  conv_time_a: assert property (
    seq_conv_end |=> seq_one_store)
    else $error("store step not exactly one cycle");

  no_check_a: assert property (
    do_store && cmd_r == adrc_pkg::INTERNAL_PARAM_CONVERT
    |-> store_val == prim_acc)
    else $error("unchecked command was checked");

  twin_feed_a: assert property (
    st_r == adrc_pkg::ST_CONV |-> prim_acc == red_acc)
    else $error("redundant machine diverged");

  fault_code_a: assert property (
    do_store && bad |-> store_val[15:4] == 12'hff0
                     && store_val[3:0] == flags)
    else $error("fault code malformed");

  nibble_flag_a: assert property (
    do_store && chk_on && (cfg_r.force_redundancy_fail
    || prim_acc[7:4] != red_acc[7:4]) |-> store_val[1])
    else $error("nibble flag missing");

  path_sel_a: assert property (
    cfg_r.path_select_field == 2'h3 |-> adc_bit == i_mod_bits[2])
    else $error("wrong path selected");

  force_fail_a: assert property (
    do_store && chk_on && cfg_r.force_redundancy_fail
    |=> fault_r)
    else $error("forced failure not reported");

  pass_thru_a: assert property (
    do_store && !int_cmd && !bad |=> res_r == $past(prim_acc))
    else $error("matching result altered");

endmodule

//--- hw/adrc_pkg.sv
// Purpose: Shared constants and types of the redundancy-checked result path
// Assumes: AXI4-Lite register map with one aligned 32-bit word per register
// Notes:   Result codes weigh 100 uV per count; sum code is attenuated 30:1
package adrc_pkg;

  // -----------------------------------------------------------------
  // Register byte addresses
  // -----------------------------------------------------------------
  localparam logic [7:0] A_CFG  = 8'h00;
  localparam logic [7:0] A_CMD  = 8'h04;
  localparam logic [7:0] A_SUM  = 8'h08;
  localparam logic [7:0] A_TMP  = 8'h0c;
  localparam logic [7:0] A_ASUP = 8'h10;
  localparam logic [7:0] A_DSUP = 8'h14;
  localparam logic [7:0] A_RES  = 8'h18;

  // -----------------------------------------------------------------
  // Reset values, field codes and counts
  // -----------------------------------------------------------------
  localparam logic [15:0] RES_RST      = 16'h0000;
  localparam logic [1:0]  PATH_RST     = 2'h0;
  localparam logic        FORCE_RST    = 1'b0;
  localparam logic [11:0] FAULT_HI     = 12'hff0;
  localparam logic [3:0]  ALL_NIB_BAD  = 4'hf;
  localparam logic [1:0]  PATH_FIX_MIN = 2'h2;
  localparam logic [1:0]  SLOT_SUM     = 2'h0;
  localparam logic [1:0]  SLOT_TMP     = 2'h1;
  localparam logic [1:0]  SLOT_ASUP    = 2'h2;
  localparam logic [1:0]  SLOT_DSUP    = 2'h3;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;
  localparam int          CONV_SAMPLES = 256;

  // Code scaling seen by software
  localparam int SUM_ATTEN  = 30;
  localparam int LSB_UV     = 100;
  localparam int TMP_DIV_UV = 7600;
  localparam int TMP_OFS_C  = 276;

  // -----------------------------------------------------------------
  // Types
  // -----------------------------------------------------------------
  typedef enum logic [3:0] {
    CELL_CONVERT,
    OPEN_WIRE_CONVERT,
    CELL_SELF_TEST,
    OVERLAP_CONVERT,
    AUX_CONVERT,
    AUX_CONVERT_CHECKED,
    AUX_OPEN_WIRE,
    AUX_SELF_TEST,
    INTERNAL_PARAM_CONVERT,
    INTERNAL_PARAM_CONVERT_CHECKED,
    INTERNAL_PARAM_SELF_TEST,
    CELL_AND_AUX_CONVERT,
    CELL_AND_SUM_CONVERT
  } adrc_cmd_e;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_CONV,
    ST_STORE
  } adrc_state_e;

  typedef struct packed {
    logic       force_redundancy_fail;
    logic [1:0] path_select_field;
  } adrc_cfg_s;

endpackage

//--- bench/adrc_host.sv
// Purpose: Host side model driving the AXI4-Lite register port
// Assumes: Single outstanding write and read, signals moved after posedge
// Notes:   Sets hung when a handshake never arrives within its bound
module adrc_host (
  input  wire logic        i_clk,
  output logic      [7:0]  o_awaddr,
  output logic             o_awvalid,
  output logic      [31:0] o_wdata,
  output logic      [3:0]  o_wstrb,
  output logic             o_wvalid,
  output logic             o_bready,
  output logic      [7:0]  o_araddr,
  output logic             o_arvalid,
  output logic             o_rready,
  input  wire logic        i_awready,
  input  wire logic        i_wready,
  input  wire logic [1:0]  i_bresp,
  input  wire logic        i_bvalid,
  input  wire logic        i_arready,
  input  wire logic [31:0] i_rdata,
  input  wire logic [1:0]  i_rresp,
  input  wire logic        i_rvalid
);
  timeunit 1ns;
  timeprecision 1ps;
  logic hung = 1'b0;

  // Idle bus at time zero
  initial begin
    {o_awaddr, o_awvalid, o_wdata, o_wstrb, o_wvalid, o_bready} = '0;
    {o_araddr, o_arvalid, o_rready} = '0;
  end

  // -----------------------------------------------------------------
  // Write: address and data together, response after both
  // -----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] resp);
    bit bd;
    int n;
    bd = 0;
    n = 0;
    resp = 2'h3;
    @(posedge i_clk);
    o_awaddr  <= a;
    o_awvalid <= 1'b1;
    o_wdata   <= d;
    o_wstrb   <= 4'hf;
    o_wvalid  <= 1'b1;
    o_bready  <= 1'b1;
    while (!bd) begin
      @(posedge i_clk);
      if (o_awvalid && i_awready) o_awvalid <= 1'b0;
      if (o_wvalid && i_wready) o_wvalid <= 1'b0;
      if (o_bready && i_bvalid) begin
        resp = i_bresp;
        o_bready <= 1'b0;
        bd = 1;
      end
      n++;
      if (n > 100) begin
        hung = 1'b1;
        bd = 1;
      end
    end
  endtask

  // -----------------------------------------------------------------
  // Read: flt marks codes at or above the fault level
  // -----------------------------------------------------------------
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] resp, output logic flt);
    bit bd;
    int n;
    bd = 0;
    n = 0;
    d = '0;
    resp = 2'h3;
    @(posedge i_clk);
    o_araddr  <= a;
    o_arvalid <= 1'b1;
    o_rready  <= 1'b1;
    while (!bd) begin
      @(posedge i_clk);
      if (o_arvalid && i_arready) o_arvalid <= 1'b0;
      if (o_rready && i_rvalid) begin
        d = i_rdata;
        resp = i_rresp;
        o_rready <= 1'b0;
        bd = 1;
      end
      n++;
      if (n > 100) begin
        hung = 1'b1;
        bd = 1;
      end
    end
    flt = (d[15:0] >= 16'hff00);
  endtask
endmodule

//--- bench/test_adc_digital_redundancy_check.sv
// Purpose: Self-checking bench of the redundancy-checked result path
// Assumes: Short conversions of four strobes per slot
// Notes:   Modulator bits driven here, registers through the host model
module test_adc_digital_redundancy_check;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CL = 4;
  logic        i_ref_clk = 1'b0;
  logic        i_rst_n, i_mod_stb;
  logic [2:0]  i_mod_bits;
  logic [7:0]  i_awaddr, i_araddr;
  logic        i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
  logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  logic [31:0] i_wdata, o_rdata;
  logic [3:0]  i_wstrb;
  logic [1:0]  o_bresp, o_rresp;
  int          n_fail = 0, checks_done = 0, cyc = 0;

  adrc_top #(.CONV_LEN(CL)) i_adrc_top (.i_ref_clk, .i_rst_n, .i_awaddr,
    .i_awvalid, .o_awready, .i_wdata, .i_wstrb, .i_wvalid, .o_wready,
    .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid, .o_arready,
    .o_rdata, .o_rresp, .o_rvalid, .i_rready, .i_mod_stb, .i_mod_bits);

  adrc_host i_adrc_host (.i_clk(i_ref_clk), .o_awaddr(i_awaddr),
    .o_awvalid(i_awvalid), .o_wdata(i_wdata), .o_wstrb(i_wstrb),
    .o_wvalid(i_wvalid), .o_bready(i_bready), .o_araddr(i_araddr),
    .o_arvalid(i_arvalid), .o_rready(i_rready), .i_awready(o_awready),
    .i_wready(o_wready), .i_bresp(o_bresp), .i_bvalid(o_bvalid),
    .i_arready(o_arready), .i_rdata(o_rdata), .i_rresp(o_rresp),
    .i_rvalid(o_rvalid));

  // -----------------------------------------------------------------
  // Clock, cycle count, hang watch
  // -----------------------------------------------------------------
  always #4 i_ref_clk = ~i_ref_clk;
  always @(posedge i_ref_clk) cyc <= cyc + 1;
  always @(posedge i_ref_clk) begin
    if (i_adrc_host.hung) begin
      n_fail = n_fail + 1;
      final_report();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("checks %0d errors %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e, string nm);
    logic [31:0] d;
    logic [1:0] r;
    logic f;
    i_adrc_host.rd(a, d, r, f);
    chk(nm, d, e);
    chk("rd_resp", r, adrc_pkg::RESP_OKAY);
    chk("fault_level", f, e[15:0] >= 16'hff00);
  endtask

  // Start a command, feed slots (path0 grows per slot), wait for idle
  task automatic conv(input logic [3:0] code, input int b0, output int dur);
    logic [31:0] d;
    logic [1:0] r;
    logic f;
    int t0, k, ns;
    ns = (code inside {4'd8, 4'd9, 4'd10}) ? 4 : 1;
    i_adrc_host.wr(adrc_pkg::A_CMD, {28'h0, code}, r);
    t0 = cyc;
    chk("cmd_resp", r, adrc_pkg::RESP_OKAY);
    for (int s = 0; s < ns; s++) begin
      for (int i = 0; i < CL; i++) begin
        @(posedge i_ref_clk);
        i_mod_stb  <= 1'b1;
        i_mod_bits <= {i < 3, i < 2, i < b0 + s};
        @(posedge i_ref_clk);
        i_mod_stb  <= 1'b0;
      end
      repeat (4) @(posedge i_ref_clk);
    end
    k = 0;
    d = '1;
    while (d[0] !== 1'b0) begin
      i_adrc_host.rd(adrc_pkg::A_CMD, d, r, f);
      k++;
      if (k > 60) begin
        n_fail++;
        final_report();
      end
    end
    dur = cyc - t0;
  endtask

  // -----------------------------------------------------------------
  // Main sequence
  // -----------------------------------------------------------------
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    logic f;
    int d8, d9;
    logic [15:0] e;
    i_rst_n = 1'b0;
    i_mod_stb = 1'b0;
    i_mod_bits = 3'h0;
    repeat (5) @(posedge i_ref_clk);
    i_rst_n <= 1'b1;
    chk("sum_scale", adrc_pkg::SUM_ATTEN * adrc_pkg::LSB_UV, 3000);
    chk("tmp_div", adrc_pkg::TMP_DIV_UV, 7600);
    chk("tmp_ofs", adrc_pkg::TMP_OFS_C, 276);
    rdc(adrc_pkg::A_CFG, 0, "cfg_rst");
    rdc(adrc_pkg::A_SUM, 0, "sum_rst");
    rdc(adrc_pkg::A_RES, 0, "res_rst");
    i_adrc_host.rd(8'h1c, d, r, f);
    chk("unmap_rd", {d[31:2], r}, {30'h0, adrc_pkg::RESP_SLVERR});
    i_adrc_host.wr(8'h1c, 32'h1, r);
    chk("unmap_wr", r, adrc_pkg::RESP_SLVERR);
    i_adrc_host.wr(adrc_pkg::A_SUM, 32'h1234, r);
    chk("ro_wr", r, adrc_pkg::RESP_OKAY);
    rdc(adrc_pkg::A_SUM, 0, "sum_ro");
    // Unchecked then checked internal convert, same stimulus
    conv(4'd8, 0, d8);
    for (int s = 0; s < 4; s++)
      rdc(adrc_pkg::A_SUM + 8'(4 * s), s, "slot_plain");
    conv(4'd9, 0, d9);
    chk("same_time", d9, d8);
    for (int s = 0; s < 4; s++)
      rdc(adrc_pkg::A_SUM + 8'(4 * s), s, "slot_chkd");
    // Forced failure over every command code
    i_adrc_host.wr(adrc_pkg::A_CFG, 32'h4, r);
    rdc(adrc_pkg::A_CFG, 32'h4, "cfg_wr");
    for (int c = 0; c < 13; c++) begin
      conv(4'(c), 1, d8);
      e = (c == 4 || c == 8) ? 16'h0001 : 16'hff0f;
      rdc((c inside {8, 9, 10}) ? adrc_pkg::A_SUM : adrc_pkg::A_RES,
          e, "cmd_res");
      i_adrc_host.rd(adrc_pkg::A_CMD, d, r, f);
      chk("fault_seen", d[1], e == 16'hff0f);
    end
    // Path select with force: checked only for 0 and 1
    for (int p = 0; p < 4; p++) begin
      i_adrc_host.wr(adrc_pkg::A_CFG, 32'(4 + p), r);
      conv(4'd9, 1, d8);
      e = (p < 2) ? 16'hff0f : 16'(p);
      rdc(adrc_pkg::A_SUM, e, "path_sel");
    end
    final_report();
  end
endmodule
